//--- uoie_params.svh
`ifndef UOIE_PARAMS_SVH
`define UOIE_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define UOIE_ADDR_W 8
`define UOIE_OFS_ENABLE 8'h00
`define UOIE_OFS_STATUS 8'h04
`define UOIE_OFS_RAW 8'h08

// ----------------------------------------------------------------------
// Enable register field positions
// ----------------------------------------------------------------------
`define UOIE_BIT_VBUS 0
`define UOIE_BIT_SESEND 2
`define UOIE_BIT_SESVD 3
`define UOIE_BIT_ACTV 4
`define UOIE_BIT_LSTATE 5
`define UOIE_BIT_MSTMR 6
`define UOIE_BIT_ID 7
`define UOIE_EVT_W 8
`define UOIE_IMPL_MASK 8'hfd
`define UOIE_RESET_EN 8'h00

// ----------------------------------------------------------------------
// AHB-Lite encodings
// ----------------------------------------------------------------------
`define UOIE_HTRANS_NONSEQ 2'h2
`define UOIE_HTRANS_SEQ 2'h3
`define UOIE_HRESP_OKAY 1'h0

`endif

//--- uoie_pkg.sv
package uoie_pkg;

    // Address-phase capture carried into the data phase.
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } uoie_aphase_t;

    // Per-event view: enable and pending share one layout.
    typedef struct packed {
        logic id_change;
        logic ms_timer;
        logic line_state;
        logic bus_activity;
        logic session_valid;
        logic b_session_end;
        logic unused1;
        logic a_vbus_valid;
    } uoie_evt_t;

endpackage

//--- uoie_event_latch.sv
`timescale 1ns/100ps
`include "uoie_params.svh"

// ----------------------------------------------------------------------
// Sticky pending flags, one per event bit
// ----------------------------------------------------------------------
module uoie_event_latch (
    input wire logic clk_sys, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [`UOIE_EVT_W-1:0] evt_pulse, // Event strobes from OTG status logic.
    input wire logic [`UOIE_EVT_W-1:0] clr_mask, // Write-one-to-clear strobes.
    output logic [`UOIE_EVT_W-1:0] pending // Sticky flags.
);
    localparam logic [`UOIE_EVT_W-1:0] IMPL = `UOIE_IMPL_MASK;

    genvar i;
    generate
        for (i = 0; i < `UOIE_EVT_W; i++) begin : g_flag
            // A new event wins over a clear in the same cycle so none is lost.
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    pending[i] <= 1'b0;
                end else if (!IMPL[i]) begin
                    pending[i] <= 1'b0;
                end else if (evt_pulse[i]) begin
                    pending[i] <= 1'b1;
                end else if (clr_mask[i]) begin
                    pending[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

//--- uoie_top.sv
`timescale 1ns/100ps
`include "uoie_params.svh"

module uoie_top (
    input wire logic clk_sys, // System clock, 40 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic hsel, // AHB slave select.
    input wire logic [31:0] haddr, // AHB address.
    input wire logic [1:0] htrans, // AHB transfer type.
    input wire logic hwrite, // AHB write.
    input wire logic [2:0] hsize, // AHB size.
    input wire logic [31:0] hwdata, // AHB write data.
    input wire logic hready, // AHB bus ready.
    output logic [31:0] hrdata, // AHB read data.
    output logic hreadyout, // AHB slave ready.
    output logic hresp, // AHB response.
    input wire logic [7:0] otg_event, // One-cycle OTG event strobes.
    output logic otg_irq // Level interrupt request.
);

    // ------------------------------------------------------------------
    // Internal signals
    // ------------------------------------------------------------------
    uoie_pkg::uoie_aphase_t aphase;
    uoie_pkg::uoie_aphase_t next_aphase;
    uoie_pkg::uoie_evt_t enable;
    uoie_pkg::uoie_evt_t next_enable;
    uoie_pkg::uoie_evt_t pending;
    uoie_pkg::uoie_evt_t wdata_evt;
    uoie_pkg::uoie_evt_t clr_mask;
    uoie_pkg::uoie_evt_t armed;
    uoie_pkg::uoie_evt_t rd_evt;
    logic [`UOIE_EVT_W-1:0] latch_pending;
    logic [`UOIE_EVT_W-1:0] next_pending;
    logic [`UOIE_EVT_W-1:0] impl_mask;
    logic [31:0] rd_word;
    logic take;
    logic rd_take;
    logic addr_is_enable;
    logic addr_is_status;
    logic addr_is_masked;
    logic wr_enable;
    logic wr_status;
    logic next_irq;

    assign impl_mask = `UOIE_IMPL_MASK;

    // ------------------------------------------------------------------
    // Address phase
    // ------------------------------------------------------------------
    // A transfer is taken at the edge where hsel, hready and a NONSEQ or SEQ
    // transfer meet. The data phase follows at once with hreadyout high, so
    // there are no wait states. Transfer size is not decoded: every register
    // is one aligned word, and a narrower write still lands on the low byte.
    always_comb begin
        take = 1'b0;
        if (hsel && hready) begin
            if (htrans == `UOIE_HTRANS_NONSEQ) begin
                take = 1'b1;
            end else if (htrans == `UOIE_HTRANS_SEQ) begin
                take = 1'b1;
            end
        end
    end

    assign rd_take = take && !hwrite;

    // Only the low address byte is decoded; unmapped offsets read zero.
    always_comb begin
        addr_is_enable = 1'b0;
        addr_is_status = 1'b0;
        addr_is_masked = 1'b0;
        unique case (haddr[`UOIE_ADDR_W-1:0])
            `UOIE_OFS_ENABLE: begin
                addr_is_enable = 1'b1;
            end
            `UOIE_OFS_STATUS: begin
                addr_is_status = 1'b1;
            end
            `UOIE_OFS_RAW: begin
                addr_is_masked = 1'b1;
            end
            default: begin
                addr_is_enable = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_aphase = aphase;
        if (hready) begin
            next_aphase.valid = take;
            next_aphase.write = hwrite;
            next_aphase.addr = haddr[`UOIE_ADDR_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aphase <= '0;
        end else begin
            aphase <= next_aphase;
        end
    end

    // ------------------------------------------------------------------
    // Data phase
    // ------------------------------------------------------------------
    // A write lands at the end of its data phase, the only cycle with valid hwdata.
    always_comb begin
        wr_enable = 1'b0;
        wr_status = 1'b0;
        if (aphase.valid && aphase.write) begin
            unique case (aphase.addr)
                `UOIE_OFS_ENABLE: begin
                    wr_enable = 1'b1;
                end
                `UOIE_OFS_STATUS: begin
                    wr_status = 1'b1;
                end
                default: begin
                    wr_enable = 1'b0;
                end
            endcase
        end
    end

    // Field positions come from the register map, not from the struct order.
    always_comb begin
        wdata_evt = '0;
        wdata_evt.id_change = hwdata[`UOIE_BIT_ID];
        wdata_evt.ms_timer = hwdata[`UOIE_BIT_MSTMR];
        wdata_evt.line_state = hwdata[`UOIE_BIT_LSTATE];
        wdata_evt.bus_activity = hwdata[`UOIE_BIT_ACTV];
        wdata_evt.session_valid = hwdata[`UOIE_BIT_SESVD];
        wdata_evt.b_session_end = hwdata[`UOIE_BIT_SESEND];
        wdata_evt.a_vbus_valid = hwdata[`UOIE_BIT_VBUS];
    end

    // Zero wait states: every transfer completes in its first data cycle.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // No transfer is ever refused, so the response stays OKAY.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hresp <= `UOIE_HRESP_OKAY;
        end else begin
            hresp <= `UOIE_HRESP_OKAY;
        end
    end

    // ------------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------------
    // Bits 31..8 have no storage and bit 1 is always loaded with zero, so a write can never set them.
    always_comb begin
        next_enable = enable;
        if (wr_enable) begin
            next_enable.id_change = wdata_evt.id_change;
            next_enable.ms_timer = wdata_evt.ms_timer;
            next_enable.line_state = wdata_evt.line_state;
            next_enable.bus_activity = wdata_evt.bus_activity;
            next_enable.session_valid = wdata_evt.session_valid;
            next_enable.b_session_end = wdata_evt.b_session_end;
            next_enable.unused1 = 1'b0;
            next_enable.a_vbus_valid = wdata_evt.a_vbus_valid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            enable <= `UOIE_RESET_EN;
        end else begin
            enable <= next_enable;
        end
    end

    // ------------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------------
    always_comb begin
        clr_mask = '0;
        if (wr_status) begin
            clr_mask = wdata_evt;
        end
    end

    uoie_event_latch u_latch (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .evt_pulse(otg_event),
        .clr_mask(clr_mask),
        .pending(latch_pending)
    );

    assign pending = latch_pending;

    // The look-ahead keeps the latch's priority, set over clear, so a read
    // whose address phase meets a clear returns the value that will stand.
    genvar b;
    generate
        for (b = 0; b < `UOIE_EVT_W; b++) begin : g_ahead
            always_comb begin
                next_pending[b] = 1'b0;
                if (impl_mask[b]) begin
                    if (otg_event[b]) begin
                        next_pending[b] = 1'b1;
                    end else if (latch_pending[b] && !clr_mask[b]) begin
                        next_pending[b] = 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Reads see the values that stand during their data phase, so a read
    // right behind a write returns the newly written value, not the old one.
    always_comb begin
        rd_evt = '0;
        if (addr_is_enable) begin
            rd_evt = next_enable;
        end else if (addr_is_status) begin
            rd_evt = next_pending;
        end else if (addr_is_masked) begin
            rd_evt = next_pending & next_enable;
        end
    end

    // Positions that are never assigned read zero.
    always_comb begin
        rd_word = '0;
        if (rd_take) begin
            rd_word[`UOIE_BIT_ID] = rd_evt.id_change;
            rd_word[`UOIE_BIT_MSTMR] = rd_evt.ms_timer;
            rd_word[`UOIE_BIT_LSTATE] = rd_evt.line_state;
            rd_word[`UOIE_BIT_ACTV] = rd_evt.bus_activity;
            rd_word[`UOIE_BIT_SESVD] = rd_evt.session_valid;
            rd_word[`UOIE_BIT_SESEND] = rd_evt.b_session_end;
            rd_word[`UOIE_BIT_VBUS] = rd_evt.a_vbus_valid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hrdata <= '0;
        end else begin
            hrdata <= rd_word;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt gating
    // ------------------------------------------------------------------
    // The request is registered, so it follows a new pending flag or an
    // enable write by one cycle. Software that clears a flag and reads the
    // line at once must allow for that cycle.
    always_comb begin
        armed = '0;
        if (pending.id_change && enable.id_change) begin
            armed.id_change = 1'b1;
        end
        if (pending.ms_timer && enable.ms_timer) begin
            armed.ms_timer = 1'b1;
        end
        if (pending.line_state && enable.line_state) begin
            armed.line_state = 1'b1;
        end
        if (pending.bus_activity && enable.bus_activity) begin
            armed.bus_activity = 1'b1;
        end
        if (pending.session_valid && enable.session_valid) begin
            armed.session_valid = 1'b1;
        end
        if (pending.b_session_end && enable.b_session_end) begin
            armed.b_session_end = 1'b1;
        end
        if (pending.a_vbus_valid && enable.a_vbus_valid) begin
            armed.a_vbus_valid = 1'b1;
        end
    end

    // A masked source stays pending, so setting its enable later raises the request.
    assign next_irq = |armed;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            otg_irq <= 1'b0;
        end else begin
            otg_irq <= next_irq;
        end
    end

endmodule

//--- uoie_otg_src.sv
`timescale 1ns/100ps
// ---------------------------------
// OTG status logic stand-in
// ---------------------------------
module uoie_otg_src (
    input wire logic clk_sys, // Clock.
    input wire logic [7:0] fire, // Requests.
    output logic [7:0] otg_event // Strobes.
);
    // A request held for one cycle leaves as a one-cycle strobe.
    always_ff @(posedge clk_sys) begin
        otg_event <= fire;
    end
endmodule

//--- uoie_asserts.sv
`timescale 1ns/100ps
module uoie_asserts (
    input wire logic clk_sys, // Clock.
    input wire logic rst_n, // Reset.
    input wire logic hsel, // Select.
    input wire logic [31:0] haddr, // Address.
    input wire logic [1:0] htrans, // Type.
    input wire logic hwrite, // Write.
    input wire logic [31:0] hwdata, // Data in.
    input wire logic hready, // Ready in.
    input wire logic [31:0] hrdata, // Data out.
    input wire logic hreadyout, // Ready out.
    input wire logic hresp, // Response.
    input wire logic [7:0] otg_event, // Events.
    input wire logic otg_irq // Interrupt.
);
    logic rd_q, wr_q, we_q, re_q;
    logic [7:0] shadow;
    wire tk = hsel && hready && htrans[1] && rst_n;
    always_ff @(posedge clk_sys) begin
        rd_q <= tk && !hwrite;
        wr_q <= tk && hwrite;
        we_q <= tk && hwrite && haddr[7:0] == 8'h00;
        re_q <= tk && !hwrite && haddr[7:0] == 8'h00;
        shadow <= !rst_n ? 8'h00 : we_q ? hwdata[7:0] & 8'hfd : shadow;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence cause_s;
        (($past(otg_event, 2) & 8'hfd) != 8'h00) || $past(we_q, 2);
    endsequence
    ready_high_a: assert property (hreadyout) else $error("wait state");
    resp_okay_a: assert property (!hresp) else $error("bad response");
    idle_data_zero_a: assert property (!rd_q |-> hrdata == 32'h0) else $error("stray data");
    unused_zero_a: assert property (hrdata[31:8] == 24'h0 && !hrdata[1]) else $error("unused bit set");
    en_readback_a: assert property (re_q |-> hrdata == {24'h0, shadow}) else $error("enable readback");
    reset_quiet_a: assert property ($rose(rst_n) |-> !otg_irq && hrdata == 32'h0) else $error("reset state");
    irq_rise_a: assert property ($rose(otg_irq) |-> cause_s) else $error("irq without cause");
    irq_fall_a: assert property ($fell(otg_irq) |-> $past(wr_q, 2)) else $error("irq dropped");
endmodule
bind uoie_top uoie_asserts chk_u (.*);

//--- testbench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; $display("unexpected %0t got %h want %h", $time, a, b); end end
module testbench;
    logic clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, otg_irq, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [7:0] fire = 8'h00, otg_event;
    int err_total = 0, samples_checked = 0, en = 0, pend = 0, r = 97809;
    always #12.5 clk_sys = ~clk_sys;
    uoie_otg_src src_u (.clk_sys(clk_sys), .fire(fire), .otg_event(otg_event));
    uoie_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .otg_event(otg_event), .otg_irq(otg_irq));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic int lfsr_next(input int s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Every wait is bounded so a stuck slave ends the run.
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            err_total++;
            $display("unexpected %0t no ready from slave", $time);
            complete_run();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic pulse(input logic [7:0] e);
        fire <= e;
        @(posedge clk_sys);
        fire <= 8'h00;
        pend = pend | (e & 8'hfd);
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic check_all();
        xfer(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'(en))
        xfer(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'(pend))
        xfer(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'(pend & en))
        `CHK(otg_irq, logic'((pend & en) != 0))
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        check_all();
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            en = (1 << i) & 8'hfd;
            xfer(1'b1, 8'h00, 32'hffffff00 | (1 << i));
            pulse(8'hff);
            check_all();
            xfer(1'b1, 8'h04, 32'hff);
            pend = 0;
        end
        $display("bit test done");
        en = 8'hfd;
        xfer(1'b1, 8'h00, 32'hff);
        pulse(8'hff);
        `CHK(otg_irq, 1'b1)
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        en = 0;
        pend = 0;
        check_all();
        $display("reset rerun test done");
        for (int i = 0; i < 20; i++) begin
            r = lfsr_next(r);
            en = r & 8'hfd;
            xfer(1'b1, 8'h00, r);
            pulse(r[15:8]);
            xfer(1'b1, 8'h04, r[23:16]);
            pend = pend & ~r[23:16];
            xfer(1'b1, 8'h10, 32'hffffffff);
            check_all();
        end
        xfer(1'b0, 8'h10, 32'h0);
        `CHK(rd, 32'h0)
        $display("random test done");
        complete_run();
    end
endmodule
